/* logic/decim_pkg.sv */
package decim_pkg;

  // ------------------------------------------------------------------
  // Word widths
  // ------------------------------------------------------------------
  localparam int CTRL_W = 5;   // Modulator control field width.
  localparam int RATE_W = 3;   // Decimation rate field width.
  localparam int CFG_W  = 8;   // Configuration word: {rate, control}.
  localparam int DATA_W = 24;  // Result and status word width.
  localparam int PIN_W  = 22;  // Number of synchronised device inputs.

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CFG_CTRL_LSB = 0;  // Control field at bits 4..0.
  localparam int CFG_RATE_LSB = 5;  // Rate field at bits 7..5.
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;  // Value after rstn.
  // Pin levels after rstn: shift clock, select and direction idle high.
  localparam logic [PIN_W-1:0] PIN_IDLE = 22'h000007;
  localparam int ST_ERR  = 23;  // Status: sticky error.
  localparam int ST_PDN  = 22;  // Status: power-down active.
  localparam int ST_RDY  = 21;  // Status: result ready.
  localparam int ST_HALT = 20;  // Status: waiting for a sync pulse.
  localparam logic [DATA_W-1:0] RESULT_RST = 24'h000000;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int REF_PERIOD_NS = 100;   // ref_clk period.
  localparam int MCLK_DIV      = 4;     // Modulator clock divide ratio.
  localparam int DEC_BASE      = 8;     // Samples per result at rate 0.
  localparam int SCLK_HALF_NS  = 800;   // Least half period of shift clk.
  localparam int SETUP_NS      = 800;   // Least select-to-first-edge time.
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int SETUP_CYC =
    (SETUP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

endpackage

/* logic/decim_link_if.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Serial configuration and readout link between host and device.
// ------------------------------------------------------------------
interface decim_link_if;
  logic sclk;      // Shift clock, idles high, driven by the host.
  logic csN;       // Device select, active low.
  logic rw;        // High for read, low for write.
  logic readback_source_select;      // High selects result, low selects status.
  logic din;       // Serial data into the device.
  logic dout;      // Serial data out of the device.
  logic doutOe;    // High while the device drives dout.
  logic doutLine;  // Resolved dout level, pulled high when released.

  // The wire floats high when nobody drives it.
  assign doutLine = doutOe ? dout : 1'b1;

  modport device (
    input  sclk,
    input  csN,
    input  rw,
    input  readback_source_select,
    input  din,
    output dout,
    output doutOe
  );

  modport host (
    output sclk,
    output csN,
    output rw,
    output readback_source_select,
    output din,
    input  doutLine
  );
endinterface

/* logic/decim_device.sv */
// Implementation choices: the plain strobed port.
`timescale 1ns/1ns
// What this block does
// - Reset or hardware mode copies gain pins.
// - Reset or hardware mode copies rate pins.
// - Mode pin picks pins or last write.
// - Read shifts result or status MSB first.
// - Output changes on rise, sampled on fall.
// - Ready rises on result, drops after read.
// - Deselected: serial pins ignored, output released.
// - Direction high reads, low writes, releases output.
// - Source select: high result, low status.
// - Write bits MSB first, taken on fall.
// - Any error drives error low, sets bit.
// - Reset input clears errors, reloads configuration.
// - Power-down halts filter and clock, keeps registers.
// - Power-down entered on next clock edge.
// - Host must sync after leaving power-down.
// - Source select picks test or modulator bits.
// - Sync clears filter, restarts convolution timing.
// - In-step sync leaves convolution undisturbed.
// - Modulator clock is master clock over four.
// - Decimator clear input resets the decimator.
// - Overrange sampled each rising edge, raises error.
// - Control outputs mirror configuration control field.
module decim_device
  import decim_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  decim_link_if.device                   link,
  input  wire logic [decim_pkg::CTRL_W-1:0] gainMuxSelectIn,
  input  wire logic [decim_pkg::RATE_W-1:0] rateSelectIn,
  input  wire logic                      hwMode,
  input  wire logic                      filterSourceSelect,
  input  wire logic                      testBitstream,
  input  wire logic                      modulatorBitstream,
  input  wire logic                      overrangeFlagIn,
  input  wire logic                      decimatorClear,
  input  wire logic                      resetIn,
  input  wire logic                      syncIn,
  input  wire logic                      powerDownRequest,
  output logic [decim_pkg::CTRL_W-1:0]   modulatorControlOut,
  output logic                           modulatorClockOut,
  output logic                           resultReady,
  output logic                           errorOutN,
  output logic                           errorOe,
  output logic [decim_pkg::DATA_W-1:0]   resultWord
);
  import decim_pkg::*;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [PIN_W-1:0] pinRaw;       // All asynchronous inputs together.
  logic [PIN_W-1:0] syncA_q;      // First stage, read only by stage two.
  logic [PIN_W-1:0] syncB_q;      // Second stage.
  logic [PIN_W-1:0] syncC_q;      // Third stage.
  logic [PIN_W-1:0] clean_q;      // Filtered level, moves when B==C.
  logic [PIN_W-1:0] cleanPrev_q;  // Previous filtered level.

  // A level only changes once two stages agree, which rejects a
  // single-cycle glitch on a slow pin at the cost of one cycle.
  function automatic logic [PIN_W-1:0] agree(
    input logic [PIN_W-1:0] b,
    input logic [PIN_W-1:0] c,
    input logic [PIN_W-1:0] held
  );
    agree = (b & c) | (held & (b ^ c));
  endfunction

  assign pinRaw = {gainMuxSelectIn, rateSelectIn, hwMode,
                   filterSourceSelect, testBitstream, modulatorBitstream,
                   overrangeFlagIn, decimatorClear, resetIn, syncIn,
                   powerDownRequest, link.readback_source_select, link.din, link.rw,
                   link.csN, link.sclk};

  // Three flops per input, then the agreement filter.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // Idle levels, so no false select or clock edge follows reset.
      syncA_q     <= PIN_IDLE;
      syncB_q     <= PIN_IDLE;
      syncC_q     <= PIN_IDLE;
      clean_q     <= PIN_IDLE;
      cleanPrev_q <= PIN_IDLE;
    end else begin
      syncA_q     <= pinRaw;
      syncB_q     <= syncA_q;
      syncC_q     <= syncB_q;
      clean_q     <= agree(syncB_q, syncC_q, clean_q);
      cleanPrev_q <= clean_q;
    end
  end

  logic [CTRL_W-1:0] gainPins;   // Filtered gain/mux pins.
  logic [RATE_W-1:0] ratePins;   // Filtered rate pins.
  logic hwSel, srcSel, testBit, modBit, ovr, decClr, rstIn, syncLvl;
  logic pdnLvl, rselLvl, dinLvl, rwLvl, csNLvl, sclkLvl;
  logic [PIN_W-1:0] rise;        // One-cycle rising edges.
  logic [PIN_W-1:0] fall;        // One-cycle falling edges.

  assign {gainPins, ratePins, hwSel, srcSel, testBit, modBit, ovr, decClr,
          rstIn, syncLvl, pdnLvl, rselLvl, dinLvl, rwLvl, csNLvl,
          sclkLvl} = clean_q;
  assign rise = clean_q & ~cleanPrev_q;
  assign fall = ~clean_q & cleanPrev_q;

  // ------------------------------------------------------------------
  // Configuration register
  // ------------------------------------------------------------------
  logic [CFG_W-1:0] cfg_q;       // {rate, control}.
  logic [CFG_W-1:0] inShift_q;   // Serial input shift register.
  logic             cfgLoad;     // Last write bit just arrived.

  // Pins win while reset or hardware mode is high; otherwise the
  // most recent complete serial word stands.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RST;
    end else if (rstIn || hwSel) begin
      cfg_q <= {ratePins, gainPins};
    end else if (cfgLoad) begin
      cfg_q <= {inShift_q[CFG_W-2:0], dinLvl};
    end
  end

  assign modulatorControlOut = cfg_q[CFG_RATE_LSB-1:CFG_CTRL_LSB];

  // ------------------------------------------------------------------
  // Power-down and convolution halt
  // ------------------------------------------------------------------
  logic pdn_q;    // Power-down active.
  logic halt_q;   // Convolutions stopped until a sync arrives.

  // Entry waits for the falling edge after the filtered request, so the
  // divider sees it half a cycle later; registers are untouched.
  // enter on falling edge
  always_ff @(negedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pdn_q <= 1'b0;
    end else begin
      pdn_q <= pdnLvl;
    end
  end

  // Convolutions stay stopped after power-down until a sync edge.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      halt_q <= 1'b0;
    end else begin
      if (pdnLvl) begin
        halt_q <= 1'b1;
      end else if (rise[6]) begin
        halt_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Modulator clock divider
  // ------------------------------------------------------------------
  logic [1:0] divCnt_q;  // Position within one modulator period.
  logic       mclkTick;  // One modulator sample per period.

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q          <= 2'h0;
      modulatorClockOut <= 1'b0;
    end else if (!pdn_q) begin
      divCnt_q          <= divCnt_q + 2'h1;
      modulatorClockOut <= divCnt_q[1];
    end
  end
  assign mclkTick = !pdn_q && (divCnt_q == 2'(MCLK_DIV - 1));

  // ------------------------------------------------------------------
  // Decimator: counts ones over a rate-dependent window
  // ------------------------------------------------------------------
  logic [10:0]       decCnt_q;   // Samples taken in this window.
  logic [10:0]       decLast;    // Last sample index of the window.
  logic [DATA_W-1:0] acc_q;      // Ones counted so far.
  logic              filtBit;    // Selected filter input.
  logic              newResult;  // One-cycle result strobe.
  logic              syncClr;    // Sync arrived out of step.

  assign filtBit = srcSel ? testBit : modBit;
  assign decLast = 11'((DEC_BASE << cfg_q[CFG_W-1:CFG_RATE_LSB]) - 1);
  assign syncClr = rise[6] && (decCnt_q != 11'h000);
  assign newResult = mclkTick && !halt_q && !decClr && !syncClr &&
                     (decCnt_q == decLast);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      decCnt_q   <= 11'h000;
      acc_q      <= RESULT_RST;
      resultWord <= RESULT_RST;
    end else if (decClr) begin
      decCnt_q <= 11'h000;
      acc_q    <= RESULT_RST;
    end else if (syncClr) begin
      decCnt_q <= 11'h000;
      acc_q    <= RESULT_RST;
    end else if (newResult) begin
      decCnt_q   <= 11'h000;
      acc_q      <= RESULT_RST;
      resultWord <= acc_q + DATA_W'(filtBit);
    end else if (mclkTick && !halt_q) begin
      decCnt_q <= decCnt_q + 11'h001;
      acc_q    <= acc_q + DATA_W'(filtBit);
    end
  end

  // ------------------------------------------------------------------
  // Error flag
  // ------------------------------------------------------------------
  logic error_q;   // Sticky error, set wins over clear.
  logic overrun;   // A result was lost because the last was unread.

  assign overrun = newResult && resultReady;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      error_q <= 1'b0;
    end else if (ovr || overrun) begin
      error_q <= 1'b1;
    end else if (rstIn) begin
      error_q <= 1'b0;
    end
  end

  // Open drain: only ever pulls low.
  assign errorOutN = 1'b0;
  assign errorOe   = error_q;

  // ------------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------------
  logic              rdActive_q;  // Read frame in progress.
  logic              wrActive_q;  // Write frame in progress.
  logic [DATA_W-1:0] outShift_q;  // Read shift register.
  logic [3:0]        bitCnt_q;    // Write bits received.
  logic              readDone;    // Read frame closed.
  logic [DATA_W-1:0] statusWord;  // Live status.

  always_comb begin
    statusWord                         = '0;
    statusWord[ST_ERR]                 = error_q;
    statusWord[ST_PDN]                 = pdn_q;
    statusWord[ST_RDY]                 = resultReady;
    statusWord[ST_HALT]                = halt_q;
    statusWord[CFG_W-1:0]              = cfg_q;
  end

  assign readDone = rise[1] && rdActive_q;
  assign cfgLoad  = fall[0] && wrActive_q && !csNLvl &&
                    (bitCnt_q == 4'(CFG_W - 1));

  // Frames open on the select edge; a deselected port sees nothing.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdActive_q <= 1'b0;
      wrActive_q <= 1'b0;
      outShift_q <= '0;
      inShift_q  <= CFG_RST;
      bitCnt_q   <= 4'h0;
    end else if (csNLvl) begin
      rdActive_q <= 1'b0;
      wrActive_q <= 1'b0;
    end else if (fall[1]) begin
      rdActive_q <= rwLvl;
      wrActive_q <= !rwLvl;
      outShift_q <= rselLvl ? resultWord : statusWord;
      bitCnt_q   <= 4'h0;
    end else if (rise[0] && rdActive_q) begin
      outShift_q <= {outShift_q[DATA_W-2:0], 1'b0};
    end else if (fall[0] && wrActive_q) begin
      inShift_q <= {inShift_q[CFG_W-2:0], dinLvl};
      bitCnt_q  <= bitCnt_q + 4'h1;
      // Extra bits after a full word are dropped.
      if (cfgLoad) begin
        wrActive_q <= 1'b0;
      end
    end
  end

  assign link.dout   = outShift_q[DATA_W-1];
  assign link.doutOe = rdActive_q && !csNLvl && rwLvl;

  // ------------------------------------------------------------------
  // Result ready
  // ------------------------------------------------------------------
  // set on result, cleared by read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      resultReady <= 1'b0;
    end else if (newResult) begin
      resultReady <= 1'b1;
    end else if (readDone) begin
      resultReady <= 1'b0;
    end
  end
endmodule

/* logic/decim_host.sv */
`timescale 1ns/1ns
module decim_host
  import decim_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  decim_link_if.host                     link,
  input  wire logic                      startRead,
  input  wire logic                      startWrite,
  input  wire logic                      readSel,
  input  wire logic [decim_pkg::CFG_W-1:0] wrData,
  output logic                           busy,
  output logic [decim_pkg::DATA_W-1:0]   rdData,
  output logic                           rdValid
);
  import decim_pkg::*;

  // ------------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_SETUP = 5'b00010,
    H_LOW   = 5'b00100,
    H_HIGH  = 5'b01000,
    H_HOLD  = 5'b10000
  } hstate_t;

  hstate_t           state_q;    // Sequencer state.
  logic [7:0]        wait_q;     // Cycles spent in the current phase.
  logic [4:0]        bitCnt_q;   // Falling edges given so far.
  logic [4:0]        nBits_q;    // Bits in this frame.
  logic [CFG_W-1:0]  wrShift_q;  // Remaining write bits.
  logic [DATA_W-1:0] rdShift_q;  // Collected read bits.
  logic              isRead_q;   // Frame is a read.
  logic              phaseEnd;   // Current half period is over.

  // Half periods are long enough for the device's three-flop input
  // path to see each edge well before the next one.
  assign phaseEnd = (state_q == H_SETUP) ? (wait_q == 8'(SETUP_CYC - 1))
                                         : (wait_q == 8'(SCLK_HALF_CYC - 1));
  // Busy also covers the deselect gap that the link needs between frames.
  assign busy     = (state_q != H_IDLE) || !phaseEnd;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= H_IDLE;
      // Gap counter starts full, so a start is taken at once.
      wait_q    <= 8'(SCLK_HALF_CYC - 1);
      bitCnt_q  <= 5'h00;
      nBits_q   <= 5'h00;
      wrShift_q <= '0;
      rdShift_q <= '0;
      isRead_q  <= 1'b0;
      rdData    <= '0;
      rdValid   <= 1'b0;
      link.sclk <= 1'b1;
      link.csN  <= 1'b1;
      link.rw   <= 1'b1;
      link.readback_source_select <= 1'b0;
      link.din  <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      wait_q  <= phaseEnd ? 8'h00 : wait_q + 8'h01;
      case (state_q)
        H_IDLE: begin
          if (!phaseEnd) begin
            // Select stays high one half period between frames.
            wait_q <= wait_q + 8'h01;
          end else if (startRead) begin
            wait_q    <= 8'h00;
            link.csN  <= 1'b0;
            link.rw   <= 1'b1;
            link.readback_source_select <= readSel;
            isRead_q  <= 1'b1;
            nBits_q   <= 5'(DATA_W);
            bitCnt_q  <= 5'h00;
            state_q   <= H_SETUP;
          end else if (startWrite) begin
            wait_q    <= 8'h00;
            link.csN  <= 1'b0;
            link.rw   <= 1'b0;
            link.din  <= wrData[CFG_W-1];
            wrShift_q <= {wrData[CFG_W-2:0], 1'b0};
            isRead_q  <= 1'b0;
            nBits_q   <= 5'(CFG_W);
            bitCnt_q  <= 5'h00;
            state_q   <= H_SETUP;
          end else begin
            wait_q <= wait_q;
          end
        end
        H_SETUP: begin
          if (phaseEnd) begin
            link.sclk <= 1'b0;
            rdShift_q <= {rdShift_q[DATA_W-2:0], link.doutLine};
            bitCnt_q  <= bitCnt_q + 5'h01;
            state_q   <= H_LOW;
          end
        end
        H_LOW: begin
          if (phaseEnd) begin
            link.sclk <= 1'b1;
            link.din  <= wrShift_q[CFG_W-1];
            wrShift_q <= {wrShift_q[CFG_W-2:0], 1'b0};
            state_q   <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (phaseEnd) begin
            if (bitCnt_q == nBits_q) begin
              state_q <= H_HOLD;
            end else begin
              link.sclk <= 1'b0;
              rdShift_q <= {rdShift_q[DATA_W-2:0], link.doutLine};
              bitCnt_q  <= bitCnt_q + 5'h01;
              state_q   <= H_LOW;
            end
          end
        end
        H_HOLD: begin
          if (phaseEnd) begin
            link.csN <= 1'b1;
            if (isRead_q) begin
              rdData  <= rdShift_q;
              rdValid <= 1'b1;
            end
            state_q <= H_IDLE;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end
endmodule

/* verif/decim_link_checker.sv */
`timescale 1ns/1ns
// -------------------------------------------------------------
// Watches the serial link between the host and device ends.
// -------------------------------------------------------------
module decim_link_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic csN,
  input wire logic rw,
  input wire logic readback_source_select,
  input wire logic din,
  input wire logic dout,
  input wire logic doutOe
);
  logic [5:0] falls_q;  // Shift clock falls in the open frame.
  logic       rdFrm_q;  // Direction of the open frame.
  logic       sclk_q;   // Shift clock one cycle ago.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Falls are counted per frame so the word length can be judged.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      falls_q <= 6'h00;
    end else if (csN) begin
      falls_q <= 6'h00;
    end else if (sclk_q && !sclk) begin
      falls_q <= falls_q + 6'h01;
    end
  end

  // Direction and previous clock are kept for the frame end.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdFrm_q <= 1'b0;
      sclk_q  <= 1'b1;
    end else begin
      sclk_q <= sclk;
      if (!csN) begin
        rdFrm_q <= rw;
      end
    end
  end

  a_idle_release: assert property (csN [*8] |-> !doutOe)
    else $error("dout driven while deselected");
  a_write_release: assert property ((!csN && !rw) [*8] |-> !doutOe)
    else $error("dout driven in a write frame");
  a_read_drives: assert property ((!csN && rw) [*8] |-> doutOe)
    else $error("dout not driven in a read frame");
  a_dout_steady_low: assert property (!sclk && doutOe |-> $stable(dout))
    else $error("dout moved while shift clock low");
  a_din_steady_fall: assert property (
    !csN && !rw && $fell(sclk) |-> $stable(din))
    else $error("din moved at the sampling edge");
  a_frame_setup: assert property ($fell(csN) |-> sclk [*8])
    else $error("shift clock fell too soon after select");
  a_half_period: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("shift clock low phase too short");
  a_idle_sclk: assert property (csN |-> sclk)
    else $error("shift clock not idle high");
  a_frame_bounded: assert property ($fell(csN) |-> ##[1:1000] csN)
    else $error("frame never closed");
  a_bit_count: assert property (
    $rose(csN) |-> falls_q == (rdFrm_q ? 6'h18 : 6'h08))
    else $error("wrong number of bits in frame");
  a_dir_stable: assert property (
    !csN && !$past(csN) |-> $stable(rw) && $stable(readback_source_select))
    else $error("direction or source moved in frame");

  c_read: cover property ($rose(csN) && rdFrm_q);
  c_write: cover property ($rose(csN) && !rdFrm_q);
  c_drive: cover property ($rose(doutOe));
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import decim_pkg::*;
  logic              ref_clk, rstn, hwMode, srcSel, testBits, modBits;
  logic              ovr, decClr, rstIn, sync, pdn, mclk, resultReady;
  logic              errorOe, startRead, startWrite, readSel, busy, rdValid;
  logic [CTRL_W-1:0] gain, modCtl;
  logic [RATE_W-1:0] rate;
  logic [CFG_W-1:0]  wrData, v;
  logic [DATA_W-1:0] rdData, resultWord, rd;
  logic [31:0]       seed = 32'h20B4083C;  // Fixed so runs repeat.
  int                n_errors, samples_checked, cycles, k, n, last, per;
  logic              p;
  logic              errN;  // Open-drain error drive value, always low; the pin is low only while errorOe.

  decim_link_if link();
  decim_device i_decim_device (.ref_clk(ref_clk), .rstn(rstn), .link(link),
    .gainMuxSelectIn(gain), .rateSelectIn(rate), .hwMode(hwMode),
    .filterSourceSelect(srcSel), .testBitstream(testBits),
    .modulatorBitstream(modBits), .overrangeFlagIn(ovr),
    .decimatorClear(decClr), .resetIn(rstIn), .syncIn(sync),
    .powerDownRequest(pdn), .modulatorControlOut(modCtl),
    .modulatorClockOut(mclk), .resultReady(resultReady), .errorOutN(errN),
    .errorOe(errorOe), .resultWord(resultWord));
  decim_host i_decim_host (.ref_clk(ref_clk), .rstn(rstn), .link(link),
    .startRead(startRead), .startWrite(startWrite), .readSel(readSel),
    .wrData(wrData), .busy(busy), .rdData(rdData), .rdValid(rdValid));
  decim_link_checker i_chk (.ref_clk(ref_clk), .rstn(rstn),
    .sclk(link.sclk), .csN(link.csN), .rw(link.rw), .readback_source_select(link.readback_source_select),
    .din(link.din), .dout(link.dout), .doutOe(link.doutOe));

  // Xorshift source; the bitstream draws from it every cycle.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) modBits <= ^rnd();

  // Watchdog: the tests need well under this many cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic checkWord(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitCyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  // One read frame; the word is taken at the rdValid edge.
  task automatic hostRead(input logic sel, output logic [23:0] d);
    int t;
    while (busy !== 1'b0) @(posedge ref_clk);
    startRead <= 1'b1;
    readSel   <= sel;
    @(posedge ref_clk);
    startRead <= 1'b0;
    t = 0;
    do begin @(posedge ref_clk); t++; end
    while (rdValid !== 1'b1 && t < 600);
    if (rdValid !== 1'b1) n_errors++;
    d = rdData;
    @(posedge ref_clk);
  endtask

  task automatic hostWrite(input logic [7:0] w);
    int t;
    while (busy !== 1'b0) @(posedge ref_clk);
    startWrite <= 1'b1;
    wrData     <= w;
    @(posedge ref_clk);
    startWrite <= 1'b0;
    t = 0;
    do begin @(posedge ref_clk); t++; end
    while (busy !== 1'b0 && t < 300);
    if (busy !== 1'b0) n_errors++;
  endtask

  initial begin
    {rstn, startRead, startWrite, readSel, srcSel, testBits} = 6'h00;
    {ovr, decClr, rstIn, sync, pdn} = 5'h00;
    {wrData, gain, rate, hwMode} = 17'h00001;
    waitCyc(10);
    rstn <= 1'b1;
    waitCyc(2);
    // Pins drive control outputs and configuration in hardware mode.
    for (int i = 0; i < 3; i++) begin
      gain <= CTRL_W'(rnd());
      rate <= RATE_W'(rnd());
      waitCyc(8);
      checkWord(24'(modCtl), 24'(gain));
      hostRead(1'b0, rd);
      checkWord(24'(rd[19:0]), {16'h0000, rate, gain});
    end
    $display("test pins done");
    // Serial writes rule once pins are set aside; gain pins differ on purpose.
    hwMode <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      v = CFG_W'(rnd());
      gain <= ~v[4:0];
      hostWrite(v);
      waitCyc(8);
      checkWord(24'(modCtl), 24'(v[4:0]));
      hostRead(1'b0, rd);
      checkWord(24'(rd[19:0]), 24'(v));
    end
    hwMode <= 1'b1;
    waitCyc(8);
    checkWord(24'(modCtl), 24'(gain));
    $display("test serial config done");
    // Modulator clock period, then its halt in power-down.
    last = 0;
    per = 0;
    p = mclk;
    for (int i = 1; i < 40; i++) begin
      @(posedge ref_clk);
      if (mclk && !p) begin per = i - last; last = i; end
      p = mclk;
    end
    checkWord(24'(per), 24'(MCLK_DIV));
    pdn <= 1'b1;
    waitCyc(10);
    p = mclk;
    n = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      n += int'(mclk !== p);
    end
    checkWord(24'(n), 24'h000000);
    hostRead(1'b0, rd);
    checkWord(24'(rd[ST_PDN]), 24'h000001);
    pdn <= 1'b0;
    $display("test clock done");
    // Test bits all ones at the slowest rate give a known sum.
    rate <= 3'h7;
    srcSel <= 1'b1;
    testBits <= 1'b1;
    waitCyc(8);
    sync <= 1'b1;
    waitCyc(8);
    sync <= 1'b0;
    hostRead(1'b1, rd);
    waitCyc(8);
    checkWord(24'(resultReady), 24'h000000);
    rstIn <= 1'b1;
    waitCyc(8);
    rstIn <= 1'b0;
    waitCyc(8);
    checkWord(24'(errorOe), 24'h000000);
    ovr <= 1'b1;
    waitCyc(8);
    ovr <= 1'b0;
    waitCyc(8);
    checkWord(24'(errorOe), 24'h000001);
    checkWord(24'(errorOe ? errN : 1'b1), 24'h000000);
    k = 0;
    while (resultReady !== 1'b1 && k < 6000) begin
      @(posedge ref_clk);
      k++;
    end
    if (resultReady !== 1'b1) n_errors++;
    checkWord(resultWord, 24'(DEC_BASE << 7));
    hostRead(1'b0, rd);
    checkWord(24'(rd[23:20]), 24'h00000A);
    hostRead(1'b1, rd);
    checkWord(rd, 24'(DEC_BASE << 7));
    // Held in clear at the fastest rate no result appears; then one does.
    decClr <= 1'b1;
    rate <= 3'h0;
    waitCyc(200);
    checkWord(24'(resultReady), 24'h000000);
    decClr <= 1'b0;
    waitCyc(50);
    checkWord(resultWord, 24'(DEC_BASE));
    $display("test filter done");
    test_done();
  end
endmodule
